// [rtl/csp_pkg.sv]
/*
 * Shared constants, field layouts and state encodings of the codec serial port link.
 * Assumes both ends run on clk_sys_i at 125 MHz.
 */
// Functional notes
// - System resyncs enable and reset with flop
// - Cascade output feeds next device input
// - Last device output goes to host
// - All devices share serial clock frequency, phase
// - Host takes serial clock as input
// - Every serial word is 16 bits
// - Each word has its own frame sync
// - Codec drives frame sync of outgoing words
// - Loopback: host sync derived; direct: host drives
// - Sync one clock before word MSB
// - Frame syncs are active high
// - Two sample words every sample period
// - Mixed direct mode takes variable word count
// - Host sends control words before DAC word
// - Loopback control write repeats previous sample
// - Reset enters program mode, no conversions
// - Host sends second codec word first; the device puts the first DAC word of a frame on dac_codec0_o
// - Device count resets 000b, single 001b
package csp_pkg;
	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_HALF_NS  = 64;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] DIV_LAST = 3'(SCLK_HALF_CYC - 1);
	// ************************************************
	// Word and frame layout
	// ************************************************
	localparam int WORD_BITS = 16;
	localparam logic [3:0] LAST_BIT  = 4'(WORD_BITS - 1);
	localparam logic [5:0] SLOT_SYNC0 = 6'h00;
	localparam logic [5:0] SLOT_SYNC1 = 6'(WORD_BITS + 1);
	localparam logic [5:0] SLOT_LAST  = 6'h3f;
	localparam int CW_CTRL_BIT  = 15;
	localparam int CW_ADDR_LSB  = 11;
	localparam int MODE_LSB     = 0;
	localparam int DEVCNT_LSB   = 4;
	localparam logic [2:0] REG_A = 3'h0;
	// ************************************************
	// Modes and reset values
	// ************************************************
	localparam logic [1:0] MODE_PROGRAM = 2'h0;
	localparam logic [1:0] MODE_DATA    = 2'h1;
	localparam logic [1:0] MODE_MIXED   = 2'h3;
	localparam logic [2:0] DEVCNT_RESET  = 3'h0;
	localparam logic [2:0] DEVCNT_SINGLE = 3'h1;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	typedef enum logic [1:0] {
		CSP_RX_IDLE  = 2'b00,
		CSP_RX_SHIFT = 2'b01
	} csp_rx_state_t;
	typedef enum logic [1:0] {
		CSP_TX_IDLE  = 2'b00,
		CSP_TX_SYNC  = 2'b01,
		CSP_TX_SHIFT = 2'b11
	} csp_tx_state_t;
endpackage : csp_pkg

// [rtl/csp_if.sv]
/*
 * Link between the codec end and the host end.
 * Assumes the bench joins one device to one host; a cascade chains serial_out_line
 * and out_frame_sync of one device into serial_in_line and in_frame_sync of the next.
 */
`timescale 1ns/10ps
interface csp_if;
	logic sclk;
	logic serial_out_line;
	logic out_frame_sync;
	logic serial_in_line;
	logic in_frame_sync;
	logic port_gate_enable;
	logic codec_reset;
	// Device output pair lands on host receive side
	modport dev (
		output sclk,
		output serial_out_line,
		output out_frame_sync,
		input  serial_in_line,
		input  in_frame_sync,
		input  port_gate_enable,
		input  codec_reset
	);
	modport host (
		input  sclk,
		input  serial_out_line,
		input  out_frame_sync,
		output serial_in_line,
		output in_frame_sync,
		output port_gate_enable,
		output codec_reset
	);
endinterface : csp_if

// [rtl/csp_device.sv]
/*
 * Codec end: serial clock divider, framed transmit of two samples per period,
 * framed receive of control and DAC words, mode register.
 * Assumes port_gate_enable and codec_reset come from host flops on clk_sys_i.
 */
`timescale 1ns/10ps
module csp_device (
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	csp_if.dev               link,
	input  wire logic        sync_loopback_mode_i,
	input  wire logic [15:0] adc_codec0_i,
	input  wire logic [15:0] adc_codec1_i,
	output logic      [15:0] dac_codec0_o,
	output logic      [15:0] dac_codec1_o,
	output logic             dac_strobe_o,
	output logic      [15:0] ctrl_word_o,
	output logic             ctrl_strobe_o,
	output logic      [1:0]  mode_o,
	output logic      [2:0]  dev_count_o
);
	// ************************************************
	// Declarations
	// ************************************************
	logic                  rst;
	logic [2:0]            div_q;
	logic [2:0]            div_d;
	logic                  sclk_q;
	logic                  sclk_d;
	logic [5:0]            slot_q;
	logic [5:0]            slot_d;
	logic                  rise;
	logic                  fall;
	logic                  ofs_q;
	logic                  ofs_d;
	logic                  txb_q;
	logic                  txb_d;
	logic [15:0]           txsh_q;
	logic [15:0]           txsh_d;
	logic                  conv;
	logic                  rxb_s1;
	logic                  rxb_s2;
	logic                  ifs_s1;
	logic                  ifs_s2;
	logic                  frame;
	logic [15:0]           word;
	logic                  is_ctrl;
	csp_pkg::csp_rx_state_t rxst_q;
	csp_pkg::csp_rx_state_t rxst_d;
	logic [15:0]           rxsh_q;
	logic [15:0]           rxsh_d;
	logic [3:0]            rxcnt_q;
	logic [3:0]            rxcnt_d;
	logic [1:0]            mode_q;
	logic [1:0]            mode_d;
	logic [2:0]            devcnt_q;
	logic [2:0]            devcnt_d;
	logic [15:0]           ctrlw_q;
	logic [15:0]           ctrlw_d;
	logic                  ctrls_q;
	logic                  ctrls_d;
	logic [15:0]           dac0_q;
	logic [15:0]           dac0_d;
	logic [15:0]           dac1_q;
	logic [15:0]           dac1_d;
	logic                  dacs_q;
	logic                  dacs_d;
	logic                  didx_q;
	logic                  didx_d;

	// Host reset line acts like a second synchronous reset
	assign rst  = sys_rst_i | link.codec_reset;
	assign conv = (mode_q != csp_pkg::MODE_PROGRAM);

	// ************************************************
	// Serial clock and slot counter
	// ************************************************
	// Every device divides the same clock from the same reset, so all phases match
	always_comb begin
		rise   = 1'b0;
		fall   = 1'b0;
		div_d  = div_q + 3'h1;
		sclk_d = sclk_q;
		slot_d = slot_q;
		if (!link.port_gate_enable) begin
			div_d  = 3'h0;
			sclk_d = 1'b0;
			slot_d = csp_pkg::SLOT_LAST;
		end else if (div_q == csp_pkg::DIV_LAST) begin
			div_d  = 3'h0;
			sclk_d = ~sclk_q;
			rise   = ~sclk_q;
			fall   = sclk_q;
			if (!sclk_q) begin
				slot_d = slot_q + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst) begin
			div_q  <= 3'h0;
			sclk_q <= 1'b0;
			slot_q <= csp_pkg::SLOT_LAST;
		end else begin
			div_q  <= div_d;
			sclk_q <= sclk_d;
			slot_q <= slot_d;
		end
	end

	// ************************************************
	// Transmit
	// ************************************************
	// Outputs change on rising serial clock, the far end samples on falling
	always_comb begin
		ofs_d  = ofs_q;
		txb_d  = txb_q;
		txsh_d = txsh_q;
		if (rise) begin
			ofs_d  = 1'b0;
			txb_d  = txsh_q[csp_pkg::WORD_BITS-1];
			txsh_d = {txsh_q[csp_pkg::WORD_BITS-2:0], 1'b0};
			if (slot_d == csp_pkg::SLOT_SYNC0 || slot_d == csp_pkg::SLOT_SYNC1) begin
				ofs_d  = 1'b1;
				txb_d  = 1'b0;
				if (!conv) begin
					txsh_d = csp_pkg::WORD_ZERO;
				end else if (slot_d == csp_pkg::SLOT_SYNC0) begin
					txsh_d = adc_codec0_i;
				end else begin
					txsh_d = adc_codec1_i;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst) begin
			ofs_q  <= 1'b0;
			txb_q  <= 1'b0;
			txsh_q <= csp_pkg::WORD_ZERO;
		end else begin
			ofs_q  <= ofs_d;
			txb_q  <= txb_d;
			txsh_q <= txsh_d;
		end
	end

	assign link.sclk            = sclk_q;
	assign link.serial_out_line = txb_q;
	assign link.out_frame_sync  = ofs_q;

	// ************************************************
	// Receive and mode control
	// ************************************************
	always_ff @(posedge clk_sys_i) begin
		if (rst) begin
			rxb_s1 <= 1'b0;
			rxb_s2 <= 1'b0;
			ifs_s1 <= 1'b0;
			ifs_s2 <= 1'b0;
		end else begin
			rxb_s1 <= link.serial_in_line;
			rxb_s2 <= rxb_s1;
			ifs_s1 <= link.in_frame_sync;
			ifs_s2 <= ifs_s1;
		end
	end

	always_comb begin
		frame    = sync_loopback_mode_i ? ofs_q : ifs_s2;
		word     = {rxsh_q[csp_pkg::WORD_BITS-2:0], rxb_s2};
		is_ctrl  = (mode_q == csp_pkg::MODE_PROGRAM) ||
		           (mode_q == csp_pkg::MODE_MIXED && word[csp_pkg::CW_CTRL_BIT]);
		rxst_d   = rxst_q;
		rxsh_d   = rxsh_q;
		rxcnt_d  = rxcnt_q;
		mode_d   = mode_q;
		devcnt_d = devcnt_q;
		ctrlw_d  = ctrlw_q;
		ctrls_d  = 1'b0;
		dac0_d   = dac0_q;
		dac1_d   = dac1_q;
		dacs_d   = 1'b0;
		didx_d   = didx_q;
		if (rise && slot_d == csp_pkg::SLOT_SYNC0) begin
			didx_d = 1'b0;
		end
		if (fall) begin
			case (rxst_q)
				csp_pkg::CSP_RX_IDLE: begin
					if (frame) begin
						rxst_d  = csp_pkg::CSP_RX_SHIFT;
						rxcnt_d = 4'h0;
					end
				end
				csp_pkg::CSP_RX_SHIFT: begin
					rxsh_d  = word;
					rxcnt_d = rxcnt_q + 4'h1;
					if (rxcnt_q == csp_pkg::LAST_BIT) begin
						rxst_d = csp_pkg::CSP_RX_IDLE;
						if (is_ctrl) begin
							ctrlw_d = word;
							ctrls_d = 1'b1;
							if (word[csp_pkg::CW_ADDR_LSB +: 3] == csp_pkg::REG_A) begin
								mode_d   = word[csp_pkg::MODE_LSB +: 2];
								devcnt_d = word[csp_pkg::DEVCNT_LSB +: 3];
							end
						end else if (!didx_q) begin
							dac0_d = word;
							didx_d = 1'b1;
							dacs_d = 1'b1;
						end else begin
							dac1_d = word;
							dacs_d = 1'b1;
						end
					end
				end
				default: begin
					rxst_d = csp_pkg::CSP_RX_IDLE;
				end
			endcase
		end
	end

	// In mixed mode a control word in a DAC slot leaves the DAC holding its old sample; data mode writes every word to the DAC
	always_ff @(posedge clk_sys_i) begin
		if (rst) begin
			rxst_q   <= csp_pkg::CSP_RX_IDLE;
			rxsh_q   <= csp_pkg::WORD_ZERO;
			rxcnt_q  <= 4'h0;
			mode_q   <= csp_pkg::MODE_PROGRAM;
			devcnt_q <= csp_pkg::DEVCNT_RESET;
			ctrlw_q  <= csp_pkg::WORD_ZERO;
			ctrls_q  <= 1'b0;
			dac0_q   <= csp_pkg::WORD_ZERO;
			dac1_q   <= csp_pkg::WORD_ZERO;
			dacs_q   <= 1'b0;
			didx_q   <= 1'b0;
		end else begin
			rxst_q   <= rxst_d;
			rxsh_q   <= rxsh_d;
			rxcnt_q  <= rxcnt_d;
			mode_q   <= mode_d;
			devcnt_q <= devcnt_d;
			ctrlw_q  <= ctrlw_d;
			ctrls_q  <= ctrls_d;
			dac0_q   <= dac0_d;
			dac1_q   <= dac1_d;
			dacs_q   <= dacs_d;
			didx_q   <= didx_d;
		end
	end

	assign dac_codec0_o  = dac0_q;
	assign dac_codec1_o  = dac1_q;
	assign dac_strobe_o  = dacs_q;
	assign ctrl_word_o   = ctrlw_q;
	assign ctrl_strobe_o = ctrls_q;
	assign mode_o        = mode_q;
	assign dev_count_o   = devcnt_q;
endmodule : csp_device

// [rtl/csp_host.sv]
/*
 * Host end: samples the codec serial clock, receives framed words and sends
 * framed words in loopback or direct sync mode.
 * Assumes the codec makes the serial clock and the host runs on clk_sys_i.
 */
`timescale 1ns/10ps
module csp_host (
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	csp_if.host              link,
	input  wire logic        sync_loopback_mode_i,
	input  wire logic        port_en_i,
	input  wire logic        codec_reset_i,
	input  wire logic [15:0] tx_data_i,
	input  wire logic        tx_valid_i,
	output logic             tx_ready_o,
	output logic      [15:0] rx_data_o,
	output logic             rx_valid_o
);
	// ************************************************
	// Declarations
	// ************************************************
	logic                   sclk_s1;
	logic                   sclk_s2;
	logic                   sclk_s3;
	logic                   rxb_s1;
	logic                   rxb_s2;
	logic                   ofs_s1;
	logic                   ofs_s2;
	logic                   rise;
	logic                   fall;
	logic                   gate_q;
	logic                   crst_q;
	logic [15:0]            word;
	csp_pkg::csp_rx_state_t rxst_q;
	csp_pkg::csp_rx_state_t rxst_d;
	logic [15:0]            rxsh_q;
	logic [15:0]            rxsh_d;
	logic [3:0]             rxcnt_q;
	logic [3:0]             rxcnt_d;
	logic [15:0]            rxd_q;
	logic [15:0]            rxd_d;
	logic                   rxv_q;
	logic                   rxv_d;
	csp_pkg::csp_tx_state_t txst_q;
	csp_pkg::csp_tx_state_t txst_d;
	logic [15:0]            txsh_q;
	logic [15:0]            txsh_d;
	logic [3:0]             txcnt_q;
	logic [3:0]             txcnt_d;
	logic                   ifs_q;
	logic                   ifs_d;
	logic                   txb_q;
	logic                   txb_d;
	logic                   pend_q;
	logic                   pend_d;
	logic [15:0]            hold_q;
	logic [15:0]            hold_d;
	logic                   start;

	// ************************************************
	// Pin sampling and control flops
	// ************************************************
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			rxb_s1  <= 1'b0;
			rxb_s2  <= 1'b0;
			ofs_s1  <= 1'b0;
			ofs_s2  <= 1'b0;
			gate_q  <= 1'b0;
			crst_q  <= 1'b1;
		end else begin
			sclk_s1 <= link.sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			rxb_s1  <= link.serial_out_line;
			rxb_s2  <= rxb_s1;
			ofs_s1  <= link.out_frame_sync;
			ofs_s2  <= ofs_s1;
			gate_q  <= port_en_i;
			crst_q  <= codec_reset_i;
		end
	end

	assign rise                  = sclk_s2 & ~sclk_s3;
	assign fall                  = ~sclk_s2 & sclk_s3;
	assign link.port_gate_enable = gate_q;
	assign link.codec_reset      = crst_q;

	// ************************************************
	// Receive
	// ************************************************
	always_comb begin
		word    = {rxsh_q[csp_pkg::WORD_BITS-2:0], rxb_s2};
		rxst_d  = rxst_q;
		rxsh_d  = rxsh_q;
		rxcnt_d = rxcnt_q;
		rxd_d   = rxd_q;
		rxv_d   = 1'b0;
		if (fall) begin
			case (rxst_q)
				csp_pkg::CSP_RX_IDLE: begin
					if (ofs_s2) begin
						rxst_d  = csp_pkg::CSP_RX_SHIFT;
						rxcnt_d = 4'h0;
					end
				end
				csp_pkg::CSP_RX_SHIFT: begin
					rxsh_d  = word;
					rxcnt_d = rxcnt_q + 4'h1;
					if (rxcnt_q == csp_pkg::LAST_BIT) begin
						rxst_d = csp_pkg::CSP_RX_IDLE;
						rxd_d  = word;
						rxv_d  = 1'b1;
					end
				end
				default: begin
					rxst_d = csp_pkg::CSP_RX_IDLE;
				end
			endcase
		end
	end

	// ************************************************
	// Transmit
	// ************************************************
	// Words leave in the order the user offers them, so control words go first only when the user offers them first
	always_comb begin
		txst_d     = txst_q;
		txsh_d     = txsh_q;
		txcnt_d    = txcnt_q;
		ifs_d      = ifs_q;
		txb_d      = txb_q;
		pend_d     = pend_q;
		hold_d     = hold_q;
		start      = 1'b0;
		tx_ready_o = !pend_q;
		if (tx_valid_i && !pend_q) begin
			pend_d = 1'b1;
			hold_d = tx_data_i;
		end
		case (txst_q)
			csp_pkg::CSP_TX_IDLE: begin
				start = sync_loopback_mode_i ? (fall && ofs_s2) : rise;
			end
			csp_pkg::CSP_TX_SYNC: begin
				if (rise) begin
					ifs_d   = 1'b0;
					txb_d   = txsh_q[csp_pkg::WORD_BITS-1];
					txsh_d  = {txsh_q[csp_pkg::WORD_BITS-2:0], 1'b0};
					txcnt_d = 4'h0;
					txst_d  = csp_pkg::CSP_TX_SHIFT;
				end
			end
			csp_pkg::CSP_TX_SHIFT: begin
				if (rise) begin
					if (txcnt_q == csp_pkg::LAST_BIT) begin
						txb_d  = 1'b0;
						txst_d = csp_pkg::CSP_TX_IDLE;
						start  = !sync_loopback_mode_i;
					end else begin
						txb_d   = txsh_q[csp_pkg::WORD_BITS-1];
						txsh_d  = {txsh_q[csp_pkg::WORD_BITS-2:0], 1'b0};
						txcnt_d = txcnt_q + 4'h1;
					end
				end
			end
			default: begin
				txst_d = csp_pkg::CSP_TX_IDLE;
			end
		endcase
		// Loopback frames come every slot, so an empty slot sends a zero word
		if (start && (pend_q || sync_loopback_mode_i)) begin
			txst_d = csp_pkg::CSP_TX_SYNC;
			ifs_d  = !sync_loopback_mode_i;
			txsh_d = pend_q ? hold_q : csp_pkg::WORD_ZERO;
			if (pend_q) begin
				pend_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rxst_q  <= csp_pkg::CSP_RX_IDLE;
			rxsh_q  <= csp_pkg::WORD_ZERO;
			rxcnt_q <= 4'h0;
			rxd_q   <= csp_pkg::WORD_ZERO;
			rxv_q   <= 1'b0;
			txst_q  <= csp_pkg::CSP_TX_IDLE;
			txsh_q  <= csp_pkg::WORD_ZERO;
			txcnt_q <= 4'h0;
			ifs_q   <= 1'b0;
			txb_q   <= 1'b0;
			pend_q  <= 1'b0;
			hold_q  <= csp_pkg::WORD_ZERO;
		end else begin
			rxst_q  <= rxst_d;
			rxsh_q  <= rxsh_d;
			rxcnt_q <= rxcnt_d;
			rxd_q   <= rxd_d;
			rxv_q   <= rxv_d;
			txst_q  <= txst_d;
			txsh_q  <= txsh_d;
			txcnt_q <= txcnt_d;
			ifs_q   <= ifs_d;
			txb_q   <= txb_d;
			pend_q  <= pend_d;
			hold_q  <= hold_d;
		end
	end

	assign link.serial_in_line = txb_q;
	assign link.in_frame_sync  = ifs_q;
	assign rx_data_o           = rxd_q;
	assign rx_valid_o          = rxv_q;
endmodule : csp_host

// [testbench/csp_checker.sv]
/* Concurrent checks on the wires of the codec serial link.
   Assumes the bench instantiates it beside csp_if, with everything on clk_sys_i. */
`timescale 1ns/10ps
module csp_checker (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic sclk,
	input wire logic serial_out_line,
	input wire logic out_frame_sync,
	input wire logic serial_in_line,
	input wire logic in_frame_sync,
	input wire logic port_gate_enable,
	input wire logic codec_reset
);
	// ********
	// Helpers
	// ********
	logic        off;
	logic        ofs_q;
	logic        seen_q;
	logic        seen_d;
	logic [10:0] gap_q;
	logic [10:0] gap_d;
	default clocking cb @(posedge clk_sys_i); endclocking
	// Seen flag clears while the link is off, so a stale gap never judges a fresh start
	assign off = sys_rst_i || codec_reset || !port_gate_enable;
	always_comb begin
		gap_d  = (gap_q == 11'h7ff) ? gap_q : gap_q + 11'h001;
		seen_d = seen_q;
		if (out_frame_sync && !ofs_q) begin
			gap_d  = 11'h001;
			seen_d = 1'b1;
		end
		if (off) begin
			seen_d = 1'b0;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		ofs_q  <= out_frame_sync;
		gap_q  <= gap_d;
		seen_q <= seen_d;
	end
	// ********
	// Assertions
	// ********
	sequence s_high8;
		sclk[*8] ##1 !sclk;
	endsequence
	sequence s_low8;
		(!sclk)[*8] ##1 sclk;
	endsequence
	sequence s_hold16(s);
		(s throughout (1'b1 ##15 1'b1)) ##1 !s;
	endsequence
	a_sclk_high_span: assert property (disable iff (off) $rose(sclk) |-> s_high8)
		else $error("serial clock high phase wrong");
	a_sclk_low_span: assert property (disable iff (off) $fell(sclk) |-> s_low8)
		else $error("serial clock low phase wrong");
	a_out_sync_width: assert property (disable iff (off) $rose(out_frame_sync) |-> s_hold16(out_frame_sync))
		else $error("output frame sync not one serial clock");
	a_in_sync_width: assert property (disable iff (off) $rose(in_frame_sync) |-> s_hold16(in_frame_sync))
		else $error("input frame sync not one serial clock");
	a_out_on_rise: assert property (disable iff (off)
		($changed(serial_out_line) || $changed(out_frame_sync)) |-> $rose(sclk))
		else $error("device output changed away from a clock rise");
	a_fall_stable: assert property (disable iff (off) $fell(sclk) |->
		$stable(serial_out_line) && $stable(out_frame_sync) && $stable(serial_in_line) && $stable(in_frame_sync))
		else $error("link line moved at sampling fall");
	a_in_sync_phase: assert property (disable iff (off) $rose(in_frame_sync) |-> sclk)
		else $error("host frame sync launched in low phase");
	a_sync_gap: assert property (disable iff (off)
		$rose(out_frame_sync) && seen_q |-> gap_q == 11'h110 || gap_q == 11'h2f0)
		else $error("frame sync spacing wrong");
	a_gate_stops_clock: assert property (disable iff (sys_rst_i) (!port_gate_enable)[*4] |-> !sclk)
		else $error("serial clock runs with gate off");
	a_reset_quiet: assert property (disable iff (sys_rst_i)
		codec_reset[*4] |-> !sclk && !out_frame_sync && !serial_out_line)
		else $error("device active in reset");
endmodule : csp_checker

// [testbench/codec_serial_port_cascade_bench.sv]
/* Self-checking bench: one codec end faces one host end over csp_if.
   Assumes the package, interface, both ends and csp_checker are compiled first. */
`timescale 1ns/10ps
module codec_serial_port_cascade_bench;
	// ********
	// Ends and helpers
	// ********
	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        lb;
	logic        port_en;
	logic        cod_rst;
	logic        tx_valid;
	logic        tx_ready;
	logic        rx_valid;
	logic        dac_stb;
	logic        ctrl_stb;
	logic [15:0] adc0;
	logic [15:0] adc1;
	logic [15:0] tx_data;
	logic [15:0] dac0;
	logic [15:0] dac1;
	logic [15:0] ctrl_word;
	logic [15:0] rx_data;
	logic [15:0] w;
	logic [15:0] c;
	logic [1:0]  mode;
	logic [2:0]  dev_cnt;
	logic [15:0] rx_q[$];
	int          bad_count = 0;
	int          checks = 0;
	int          seed = 45;
	int          ifs_hits = 0;
	int          dac_hits = 0;
	int          ctrl_hits = 0;
	int          dbase;
	int          cbase;
	always #4 clk_sys_i = ~clk_sys_i;
	csp_if link ();
	csp_device csp_device_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link.dev),
		.sync_loopback_mode_i(lb), .adc_codec0_i(adc0), .adc_codec1_i(adc1), .dac_codec0_o(dac0),
		.dac_codec1_o(dac1), .dac_strobe_o(dac_stb), .ctrl_word_o(ctrl_word), .ctrl_strobe_o(ctrl_stb),
		.mode_o(mode), .dev_count_o(dev_cnt));
	csp_host csp_host_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link.host),
		.sync_loopback_mode_i(lb), .port_en_i(port_en), .codec_reset_i(cod_rst), .tx_data_i(tx_data),
		.tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid));
	csp_checker csp_checker_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sclk(link.sclk),
		.serial_out_line(link.serial_out_line), .out_frame_sync(link.out_frame_sync),
		.serial_in_line(link.serial_in_line), .in_frame_sync(link.in_frame_sync),
		.port_gate_enable(link.port_gate_enable), .codec_reset(link.codec_reset));
	always @(posedge clk_sys_i) begin
		if (rx_valid === 1'b1) begin
			rx_q.push_back(rx_data);
		end
		if (lb && link.in_frame_sync !== 1'b0) begin
			ifs_hits++;
		end
		if (dac_stb === 1'b1) begin
			dac_hits++;
		end
		if (ctrl_stb === 1'b1) begin
			ctrl_hits++;
		end
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask : check
	task automatic results();
		$display("Checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	// Slot 0 is the sync rise after the long idle stretch, not the one after word 0
	task automatic wait_frame();
		int lo;
		lo = 0;
		for (int i = 0; i < 3000; i++) begin
			@(negedge clk_sys_i);
			if (link.out_frame_sync === 1'b1 && lo > 300) return;
			lo = (link.out_frame_sync === 1'b1) ? 0 : lo + 1;
		end
		check("frame wait", 16'h0001, 16'h0000);
		results();
	endtask : wait_frame
	task automatic send(input logic [15:0] d);
		for (int i = 0; i < 3000 && tx_ready !== 1'b1; i++) begin
			@(negedge clk_sys_i);
		end
		if (tx_ready !== 1'b1) begin
			check("tx ready", 16'h0001, 16'h0000);
			results();
		end
		tx_data = d;
		tx_valid = 1'b1;
		@(negedge clk_sys_i);
		tx_valid = 1'b0;
	endtask : send
	function automatic logic [15:0] cw(input logic [1:0] m);
		return 16'h8000 | (16'(csp_pkg::REG_A) << csp_pkg::CW_ADDR_LSB)
			| (16'(csp_pkg::DEVCNT_SINGLE) << csp_pkg::DEVCNT_LSB) | 16'(m);
	endfunction : cw
	// ********
	// Main sequence
	// ********
	initial begin
		lb = 1'b0;
		port_en = 1'b0;
		cod_rst = 1'b1;
		tx_valid = 1'b0;
		tx_data = 16'h0000;
		adc0 = 16'h0000;
		adc1 = 16'h0000;
		repeat (3) @(negedge clk_sys_i);
		sys_rst_i = 1'b0;
		@(negedge clk_sys_i);
		check("mode", 16'(csp_pkg::MODE_PROGRAM), 16'(mode));
		check("count", 16'(csp_pkg::DEVCNT_RESET), 16'(dev_cnt));
		cod_rst = 1'b0;
		port_en = 1'b1;
		adc0 = 16'($random(seed));
		adc1 = 16'($random(seed));
		wait_frame();
		rx_q.delete();
		send(cw(csp_pkg::MODE_MIXED));
		send(cw(csp_pkg::MODE_MIXED));
		wait_frame();
		check("ctrl", cw(csp_pkg::MODE_MIXED), ctrl_word);
		check("mode", 16'(csp_pkg::MODE_MIXED), 16'(mode));
		check("count", 16'(csp_pkg::DEVCNT_SINGLE), 16'(dev_cnt));
		check("program word", csp_pkg::WORD_ZERO, rx_q[0]);
		check("program words", 16'h0002, 16'(rx_q.size()));
		$display("Test program done");
		for (int k = 0; k < 3; k++) begin
			adc0 = 16'($random(seed));
			adc1 = (k == 2) ? 16'hffff : 16'($random(seed));
			w = (k == 0) ? 16'h7fff : 16'($random(seed)) & 16'h7fff;
			c = (k == 1) ? 16'h0000 : 16'($random(seed)) & 16'h7fff;
			wait_frame();
			rx_q.delete();
			dbase = dac_hits;
			cbase = ctrl_hits;
			send(cw(csp_pkg::MODE_MIXED));
			send(w);
			send(c);
			wait_frame();
			check("dac0", w, dac0);
			check("dac1", c, dac1);
			check("adc0", adc0, rx_q[0]);
			check("adc1", adc1, rx_q[1]);
			check("words", 16'h0002, 16'(rx_q.size()));
			check("ctrl strobes", 16'h0001, 16'(ctrl_hits - cbase));
			check("dac strobes", 16'h0002, 16'(dac_hits - dbase));
		end
		$display("Test mixed direct done");
		lb = 1'b1;
		ifs_hits = 0;
		send(cw(csp_pkg::MODE_DATA));
		for (int i = 0; i < 3000 && mode !== csp_pkg::MODE_DATA; i++) begin
			@(negedge clk_sys_i);
		end
		if (mode !== csp_pkg::MODE_DATA) begin
			check("mode wait", 16'h0001, 16'h0000);
			results();
		end
		check("loop dac0 held", w, dac0);
		check("loop ctrl", cw(csp_pkg::MODE_DATA), ctrl_word);
		check("loop mode", 16'(csp_pkg::MODE_DATA), 16'(mode));
		wait_frame();
		lb = 1'b0;
		check("loop host sync", 16'h0000, 16'(ifs_hits));
		$display("Test loopback done");
		wait_frame();
		w = 16'($random(seed)) | 16'h8000;
		send(w);
		wait_frame();
		check("data dac0", w, dac0);
		check("data ctrl", cw(csp_pkg::MODE_DATA), ctrl_word);
		$display("Test data done");
		port_en = 1'b0;
		repeat (8) @(negedge clk_sys_i);
		cod_rst = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		check("reset mode", 16'(csp_pkg::MODE_PROGRAM), 16'(mode));
		check("reset count", 16'(csp_pkg::DEVCNT_RESET), 16'(dev_cnt));
		$display("Test codec reset done");
		results();
	end
endmodule : codec_serial_port_cascade_bench
